// ==== pkg/nvbac_pkg.sv ====
package nvbac_pkg;

  // ----------------------------------------
  // Storage geometry
  // ----------------------------------------
  localparam int unsigned ADDR_W    = 9;
  localparam int unsigned MEM_BYTES = 512;

  // ----------------------------------------
  // I/O register offsets
  // ----------------------------------------
  localparam logic [5:0] OFS_CONTROL   = 6'h1c;
  localparam logic [5:0] OFS_DATA      = 6'h1d;
  localparam logic [5:0] OFS_ADDR_LOW  = 6'h1e;
  localparam logic [5:0] OFS_ADDR_HIGH = 6'h1f;

  // ----------------------------------------
  // Control and high address register fields
  // ----------------------------------------
  localparam int unsigned CTL_MODE_HI = 5;
  localparam int unsigned CTL_MODE_LO = 4;
  localparam int unsigned CTL_RIE     = 3;
  localparam int unsigned CTL_MPE     = 2;
  localparam int unsigned CTL_PE      = 1;
  localparam int unsigned CTL_RE      = 0;
  localparam int unsigned AHI_BIT8    = 0;

  // ----------------------------------------
  // Programming modes and reset values
  // ----------------------------------------
  localparam logic [1:0] MODE_ATOMIC = 2'h0;
  localparam logic [1:0] MODE_ERASE  = 2'h1;
  localparam logic [1:0] MODE_WRITE  = 2'h2;
  localparam logic [1:0] MODE_RSVD   = 2'h3;
  localparam logic [1:0] MODE_RESET  = 2'h0;
  localparam logic [7:0] ERASED_BYTE = 8'hff;
  localparam logic [7:0] BYTE_RESET  = 8'h00;

  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int unsigned CLK_PERIOD_NS     = 4;
  localparam int unsigned TICK_NS           = 1000;
  localparam int unsigned TICK_CYCLES       = TICK_NS / CLK_PERIOD_NS;
  localparam real         T_ATOMIC_MS       = 3.4;
  localparam real         T_SPLIT_MS        = 1.8;
  localparam int unsigned T_ATOMIC_TICKS    = int'(T_ATOMIC_MS * 1.0e6 / real'(TICK_NS));
  localparam int unsigned T_SPLIT_TICKS     = int'(T_SPLIT_MS * 1.0e6 / real'(TICK_NS));
  localparam int unsigned MPE_WINDOW_CYCLES = 4;
  localparam int unsigned READ_STALL_CYCLES = 4;
  localparam int unsigned PROG_STALL_CYCLES = 2;

  // ----------------------------------------
  // Programming engine states
  // ----------------------------------------
  typedef enum logic [1:0] {
    NVBAC_IDLE,
    NVBAC_FETCH,
    NVBAC_HOLD
  } nvbac_eng_state_t;

endpackage

// ==== pkg/nvbac_mem_if.sv ====
interface nvbac_mem_if;
  logic                        en;
  logic                        we;
  logic [nvbac_pkg::ADDR_W-1:0] addr;
  logic [7:0]                  wdata;
  logic [7:0]                  rdata;

  modport ctrl (output en, output we, output addr, output wdata, input rdata);
  modport mem  (input en, input we, input addr, input wdata, output rdata);
endinterface

// ==== rtl/nvbac_mem.sv ====
module nvbac_mem #(
  parameter int unsigned DEPTH = nvbac_pkg::MEM_BYTES
) (
  input  wire logic ref_clk,
  nvbac_mem_if.mem  port
);

  localparam int unsigned AW = $clog2(DEPTH);

  // ----------------------------------------
  // Byte array, registered read
  // ----------------------------------------
  logic [7:0] store [DEPTH];
  logic [7:0] rdata;

  always_ff @(posedge ref_clk) begin
    if (port.en && port.we) begin
      store[port.addr[AW-1:0]] <= port.wdata;
    end
    if (port.en && !port.we) begin
      rdata <= store[port.addr[AW-1:0]];
    end
  end

  assign port.rdata = rdata;

endmodule

// ==== rtl/nvbac_ctrl.sv ====
module nvbac_ctrl #(
  parameter int unsigned MEM_BYTES         = nvbac_pkg::MEM_BYTES,
  parameter int unsigned TICK_CYCLES       = nvbac_pkg::TICK_CYCLES,
  parameter int unsigned PROG_ATOMIC_TICKS = nvbac_pkg::T_ATOMIC_TICKS,
  parameter int unsigned PROG_SPLIT_TICKS  = nvbac_pkg::T_SPLIT_TICKS
) (
  input  wire logic       ref_clk,
  input  wire logic       rst,
  input  wire logic       por,
  input  wire logic [5:0] io_addr,
  input  wire logic       io_wr,
  input  wire logic       io_rd,
  input  wire logic [7:0] io_wdata,
  output logic      [7:0] io_rdata,
  output logic            cpu_stall,
  output logic            ready_irq
);

  localparam int unsigned AW = nvbac_pkg::ADDR_W;

  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  nvbac_mem_if mem_bus ();

  logic [AW-1:0] nv_address;
  logic [7:0]    nv_data_byte;
  logic [1:0]    prog_mode_field;
  logic          ready_irq_enable;
  logic [2:0]    mpe_cnt;
  logic [2:0]    stall_cnt;
  logic          rd_pending;
  logic [AW-1:0] next_nv_address;
  logic [7:0]    next_nv_data_byte;
  logic [1:0]    next_prog_mode_field;
  logic          next_ready_irq_enable;
  logic [2:0]    next_mpe_cnt;
  logic [2:0]    next_stall_cnt;
  logic          next_rd_pending;
  logic [7:0]    next_io_rdata;

  nvbac_pkg::nvbac_eng_state_t state;
  nvbac_pkg::nvbac_eng_state_t next_state;
  logic [11:0]   prog_cnt;
  logic [11:0]   next_prog_cnt;
  logic [7:0]    tick_cnt;
  logic [7:0]    next_tick_cnt;
  logic [AW-1:0] t_addr;
  logic [AW-1:0] next_t_addr;
  logic [7:0]    t_data;
  logic [7:0]    next_t_data;
  logic [1:0]    t_mode;
  logic [1:0]    next_t_mode;
  logic [7:0]    old_byte;
  logic [7:0]    next_old_byte;

  logic          prog_enable;
  logic          master_prog_enable;
  logic          wr_ctl;
  logic          start_req;
  logic          read_go;
  logic          tick;
  logic          prog_done;
  logic [7:0]    ctl_view;
  logic [7:0]    commit_byte;
  logic [7:0]    read_mux;
  logic [11:0]   prog_ticks;
  logic          wr_alo;
  logic          wr_ahi;
  logic          wr_dat;

  // ----------------------------------------
  // Decode
  // ----------------------------------------
  assign prog_enable        = (state != nvbac_pkg::NVBAC_IDLE);
  assign master_prog_enable = (mpe_cnt != 3'h0);
  assign wr_ctl             = io_wr && (io_addr == nvbac_pkg::OFS_CONTROL);
  assign wr_alo             = io_wr && (io_addr == nvbac_pkg::OFS_ADDR_LOW);
  assign wr_ahi             = io_wr && (io_addr == nvbac_pkg::OFS_ADDR_HIGH);
  assign wr_dat             = io_wr && (io_addr == nvbac_pkg::OFS_DATA);
  assign start_req          = wr_ctl && io_wdata[nvbac_pkg::CTL_PE] && master_prog_enable && !prog_enable
                              && (prog_mode_field != nvbac_pkg::MODE_RSVD);
  assign read_go            = wr_ctl && io_wdata[nvbac_pkg::CTL_RE] && !prog_enable && !start_req;
  assign tick               = (tick_cnt == 8'(TICK_CYCLES - 1));
  assign prog_done          = (state == nvbac_pkg::NVBAC_HOLD) && tick && (prog_cnt <= 12'h001);
  assign cpu_stall          = (stall_cnt != 3'h0);
  assign ready_irq          = ready_irq_enable && !prog_enable;

  always_comb begin
    unique case (t_mode)
      nvbac_pkg::MODE_ERASE: commit_byte = nvbac_pkg::ERASED_BYTE;
      nvbac_pkg::MODE_WRITE: commit_byte = old_byte & t_data;
      default:               commit_byte = t_data;
    endcase
  end

  // ----------------------------------------
  // Mode decode
  // ----------------------------------------
  always_comb begin
    unique case (prog_mode_field)
      nvbac_pkg::MODE_ATOMIC: prog_ticks = 12'(PROG_ATOMIC_TICKS);
      nvbac_pkg::MODE_ERASE,
      nvbac_pkg::MODE_WRITE:  prog_ticks = 12'(PROG_SPLIT_TICKS);
      default:                prog_ticks = 12'(PROG_SPLIT_TICKS);
    endcase
  end

  // ----------------------------------------
  // Register read view
  // ----------------------------------------
  always_comb begin
    ctl_view                                                = 8'h00;
    ctl_view[nvbac_pkg::CTL_MODE_HI:nvbac_pkg::CTL_MODE_LO] = prog_mode_field;
    ctl_view[nvbac_pkg::CTL_RIE]                            = ready_irq_enable;
    ctl_view[nvbac_pkg::CTL_MPE]                            = master_prog_enable;
    ctl_view[nvbac_pkg::CTL_PE]                             = prog_enable;
  end

  always_comb begin
    unique case (io_addr)
      nvbac_pkg::OFS_CONTROL:   read_mux = ctl_view;
      nvbac_pkg::OFS_DATA:      read_mux = nv_data_byte;
      nvbac_pkg::OFS_ADDR_LOW:  read_mux = nv_address[7:0];
      nvbac_pkg::OFS_ADDR_HIGH: read_mux = {7'h00, nv_address[8]};
      default:                  read_mux = 8'h00;
    endcase
  end

  // ----------------------------------------
  // Storage port
  // ----------------------------------------
  always_comb begin
    mem_bus.en    = 1'b0;
    mem_bus.we    = 1'b0;
    mem_bus.addr  = nv_address;
    mem_bus.wdata = commit_byte;
    if (prog_done) begin
      mem_bus.en   = 1'b1;
      mem_bus.we   = 1'b1;
      mem_bus.addr = t_addr;
    end else if (start_req || read_go) begin
      mem_bus.en = 1'b1;
    end
  end

  nvbac_mem #(
    .DEPTH (MEM_BYTES)
  ) u_mem (
    .ref_clk (ref_clk),
    .port    (mem_bus.mem)
  );

  // ----------------------------------------
  // I/O registers
  // ----------------------------------------
  always_comb begin
    next_nv_address       = nv_address;
    next_nv_data_byte     = nv_data_byte;
    next_prog_mode_field  = prog_mode_field;
    next_ready_irq_enable = ready_irq_enable;
    next_mpe_cnt          = master_prog_enable ? mpe_cnt - 3'h1 : 3'h0;
    next_stall_cnt        = cpu_stall ? stall_cnt - 3'h1 : 3'h0;
    next_rd_pending       = read_go;
    next_io_rdata         = io_rdata;
    if (wr_alo && !prog_enable) begin
      next_nv_address[7:0] = io_wdata;
    end
    if (wr_ahi && !prog_enable) begin
      next_nv_address[8] = io_wdata[nvbac_pkg::AHI_BIT8];
    end
    if (wr_dat) begin
      next_nv_data_byte = io_wdata;
    end
    if (wr_ctl) begin
      next_ready_irq_enable = io_wdata[nvbac_pkg::CTL_RIE];
      if (!prog_enable) begin
        next_prog_mode_field = io_wdata[nvbac_pkg::CTL_MODE_HI:nvbac_pkg::CTL_MODE_LO];
      end
      if (io_wdata[nvbac_pkg::CTL_MPE]) begin
        next_mpe_cnt = 3'(nvbac_pkg::MPE_WINDOW_CYCLES);
      end else begin
        next_mpe_cnt = 3'h0;
      end
    end
    if (start_req) begin
      next_stall_cnt = 3'(nvbac_pkg::PROG_STALL_CYCLES);
      next_mpe_cnt   = 3'h0;
    end
    if (read_go) begin
      next_stall_cnt = 3'(nvbac_pkg::READ_STALL_CYCLES);
    end
    if (rd_pending) begin
      next_nv_data_byte = mem_bus.rdata;
    end
    if (io_rd) begin
      next_io_rdata = read_mux;
    end
    if (rst || por) begin
      next_nv_address       = '0;
      next_nv_data_byte     = nvbac_pkg::BYTE_RESET;
      next_ready_irq_enable = 1'b0;
      next_mpe_cnt          = 3'h0;
      next_stall_cnt        = 3'h0;
      next_rd_pending       = 1'b0;
      next_io_rdata         = 8'h00;
      if (por || !prog_enable) begin
        next_prog_mode_field = nvbac_pkg::MODE_RESET;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    nv_address       <= next_nv_address;
    nv_data_byte     <= next_nv_data_byte;
    prog_mode_field  <= next_prog_mode_field;
    ready_irq_enable <= next_ready_irq_enable;
    mpe_cnt          <= next_mpe_cnt;
    stall_cnt        <= next_stall_cnt;
    rd_pending       <= next_rd_pending;
    io_rdata         <= next_io_rdata;
  end

  // ----------------------------------------
  // Self-timed programming engine
  // ----------------------------------------
  always_comb begin
    next_state    = state;
    next_prog_cnt = prog_cnt;
    next_tick_cnt = tick ? 8'h00 : tick_cnt + 8'h01;
    next_t_addr   = t_addr;
    next_t_data   = t_data;
    next_t_mode   = t_mode;
    next_old_byte = old_byte;
    unique case (state)
      nvbac_pkg::NVBAC_IDLE: begin
        if (start_req) begin
          next_state    = nvbac_pkg::NVBAC_FETCH;
          next_t_addr   = nv_address;
          next_t_data   = nv_data_byte;
          next_t_mode   = prog_mode_field;
          next_prog_cnt = prog_ticks;
        end
      end
      nvbac_pkg::NVBAC_FETCH: begin
        next_old_byte = mem_bus.rdata;
        next_state    = nvbac_pkg::NVBAC_HOLD;
      end
      nvbac_pkg::NVBAC_HOLD: begin
        if (prog_done) begin
          next_state = nvbac_pkg::NVBAC_IDLE;
        end else if (tick) begin
          next_prog_cnt = prog_cnt - 12'h001;
        end
      end
      default: begin
        next_state = nvbac_pkg::NVBAC_IDLE;
      end
    endcase
    if (por) begin
      next_state    = nvbac_pkg::NVBAC_IDLE;
      next_prog_cnt = 12'h000;
      next_tick_cnt = 8'h00;
      next_t_addr   = '0;
      next_t_data   = nvbac_pkg::BYTE_RESET;
      next_t_mode   = nvbac_pkg::MODE_RESET;
      next_old_byte = nvbac_pkg::BYTE_RESET;
    end
  end

  always_ff @(posedge ref_clk) begin
    state    <= next_state;
    prog_cnt <= next_prog_cnt;
    tick_cnt <= next_tick_cnt;
    t_addr   <= next_t_addr;
    t_data   <= next_t_data;
    t_mode   <= next_t_mode;
    old_byte <= next_old_byte;
  end

endmodule

// ==== tb/nvbac_ctrl_asserts.sv ====
module nvbac_ctrl_asserts #(
  parameter int unsigned TICK_CYCLES       = nvbac_pkg::TICK_CYCLES,
  parameter int unsigned PROG_ATOMIC_TICKS = nvbac_pkg::T_ATOMIC_TICKS,
  parameter int unsigned PROG_SPLIT_TICKS  = nvbac_pkg::T_SPLIT_TICKS
) (
  input wire logic       ref_clk,
  input wire logic       rst,
  input wire logic       por,
  input wire logic [5:0] io_addr,
  input wire logic       io_wr,
  input wire logic       io_rd,
  input wire logic [7:0] io_wdata,
  input wire logic [7:0] io_rdata,
  input wire logic       cpu_stall,
  input wire logic       ready_irq
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam int A_LO = (PROG_ATOMIC_TICKS - 1) * TICK_CYCLES;
  localparam int A_HI = PROG_ATOMIC_TICKS * TICK_CYCLES + 3;
  localparam int S_LO = (PROG_SPLIT_TICKS - 1) * TICK_CYCLES;
  localparam int S_HI = PROG_SPLIT_TICKS * TICK_CYCLES + 3;
  logic        wr_ctl;
  logic        rd_ctl;
  logic        start;
  logic        arm_q;
  logic        act_q;
  logic [2:0]  arm_cnt;
  logic [1:0]  arm_mode;
  logic [1:0]  act_mode;
  logic [31:0] busy_len;
  // ----------------------------------------
  // Start tracking and busy length
  // ----------------------------------------
  assign wr_ctl = io_wr && (io_addr == nvbac_pkg::OFS_CONTROL);
  assign rd_ctl = io_rd && (io_addr == nvbac_pkg::OFS_CONTROL);
  assign arm_q  = (arm_cnt != 3'h0);
  assign start  = wr_ctl && io_wdata[1] && arm_q && ready_irq;
  always_ff @(posedge ref_clk) begin
    if (rst || por) begin
      arm_cnt  <= 3'h0;
      act_q    <= 1'h0;
      arm_mode <= 2'h0;
      act_mode <= 2'h0;
      busy_len <= 32'h0;
    end else begin
      if (wr_ctl && io_wdata[2] && !(start && arm_mode != nvbac_pkg::MODE_RSVD)) begin
        arm_cnt <= 3'(nvbac_pkg::MPE_WINDOW_CYCLES);
      end else if (wr_ctl || !arm_q) begin
        arm_cnt <= 3'h0;
      end else begin
        arm_cnt <= arm_cnt - 3'h1;
      end
      if (wr_ctl && !act_q) begin
        arm_mode <= io_wdata[5:4];
      end
      if (start && arm_mode != nvbac_pkg::MODE_RSVD) begin
        act_q    <= 1'h1;
        act_mode <= arm_mode;
        busy_len <= 32'h0;
      end else if (act_q && ready_irq) begin
        act_q <= 1'h0;
      end else if (act_q) begin
        busy_len <= busy_len + 32'h1;
      end
    end
  end
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst || por);
  AST_READ_STALL: assert property (wr_ctl && io_wdata[1:0] == 2'h1 && ready_irq |=> cpu_stall [*4] ##1 !cpu_stall)
    else $error("read strobe stall length wrong");
  AST_PROG_STALL: assert property (start && arm_mode != nvbac_pkg::MODE_RSVD |=>
    (cpu_stall && !ready_irq) [*2] ##1 !cpu_stall) else $error("programming start stall wrong");
  AST_RSVD_MODE: assert property (start && arm_mode == nvbac_pkg::MODE_RSVD |=> !cpu_stall && ready_irq)
    else $error("reserved mode started programming");
  AST_PROG_TIME: assert property (act_q && ready_irq |-> (act_mode == nvbac_pkg::MODE_ATOMIC) ?
    (busy_len >= A_LO && busy_len <= A_HI) : (busy_len >= S_LO && busy_len <= S_HI))
    else $error("programming duration out of range");
  AST_MPE_OPEN: assert property (wr_ctl && io_wdata[2:1] == 2'h2 ##1 !io_wr ##1 (rd_ctl && !io_wr) |=> io_rdata[2])
    else $error("master enable lost too early");
  AST_MPE_EXPIRE: assert property (wr_ctl && io_wdata[2:1] == 2'h2 ##1 (!io_wr) [*5] ##1 (rd_ctl && !io_wr)
    |=> !io_rdata[2]) else $error("master enable not cleared");
  AST_CTL_RSVD: assert property (rd_ctl |=> io_rdata[7:6] == 2'h0 && !io_rdata[0])
    else $error("control reserved bits not zero");
  AST_AHI_ZERO: assert property (io_rd && io_addr == nvbac_pkg::OFS_ADDR_HIGH |=> io_rdata[7:1] == 7'h00)
    else $error("high address upper bits not zero");
  AST_IRQ_HOLD: assert property (ready_irq && !wr_ctl |=> $stable(ready_irq))
    else $error("ready request dropped without cause");
endmodule

bind nvbac_ctrl nvbac_ctrl_asserts #(
  .TICK_CYCLES(TICK_CYCLES), .PROG_ATOMIC_TICKS(PROG_ATOMIC_TICKS), .PROG_SPLIT_TICKS(PROG_SPLIT_TICKS)
) nvbac_ctrl_asserts_inst (
  .ref_clk(ref_clk), .rst(rst), .por(por), .io_addr(io_addr), .io_wr(io_wr), .io_rd(io_rd),
  .io_wdata(io_wdata), .io_rdata(io_rdata), .cpu_stall(cpu_stall), .ready_irq(ready_irq)
);

// ==== tb/testbench.sv ====
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [5:0] CTL = nvbac_pkg::OFS_CONTROL;
  localparam logic [5:0] DAT = nvbac_pkg::OFS_DATA;
  localparam logic [5:0] ALO = nvbac_pkg::OFS_ADDR_LOW;
  localparam logic [5:0] AHI = nvbac_pkg::OFS_ADDR_HIGH;
  logic       ref_clk;
  logic       rst;
  logic       por;
  logic       io_wr;
  logic       io_rd;
  logic       cpu_stall;
  logic       ready_irq;
  logic [5:0] io_addr;
  logic [7:0] io_wdata;
  logic [7:0] io_rdata;
  int         err_count;
  int         cmp_count;

  nvbac_ctrl #(.TICK_CYCLES(4), .PROG_ATOMIC_TICKS(6), .PROG_SPLIT_TICKS(3)) nvbac_ctrl_inst (
    .ref_clk(ref_clk), .rst(rst), .por(por), .io_addr(io_addr), .io_wr(io_wr), .io_rd(io_rd),
    .io_wdata(io_wdata), .io_rdata(io_rdata), .cpu_stall(cpu_stall), .ready_irq(ready_irq)
  );

  initial begin
    ref_clk = 1'h0;
    forever #2 ref_clk = ~ref_clk;
  end
  // ----------------------------------------
  // Access tasks
  // ----------------------------------------
  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_count++;
      $display("FAIL %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic tally_and_finish;
    $display("Comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic gap;
    int n;
    n = 0;
    @(negedge ref_clk);
    while (cpu_stall !== 1'h0 && n < 20) begin
      @(negedge ref_clk);
      n++;
    end
    if (n == 20) chk("stall release", 8'h00, 8'h01);
  endtask
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    gap();
    io_addr  = a;
    io_wdata = d;
    io_wr    = 1'h1;
    @(negedge ref_clk);
    io_wr = 1'h0;
  endtask
  task automatic rd(input logic [5:0] a, output logic [7:0] d);
    gap();
    io_addr = a;
    io_rd   = 1'h1;
    @(negedge ref_clk);
    io_rd = 1'h0;
    d     = io_rdata;
  endtask
  task automatic rdchk(input string what, input logic [5:0] a, input logic [7:0] exp);
    logic [7:0] v;
    rd(a, v);
    chk(what, v, exp);
  endtask
  task automatic wait_ready;
    logic [7:0] s;
    int n;
    s = 8'h02;
    n = 0;
    while (s[1] !== 1'h0 && n < 100) begin
      rd(CTL, s);
      n++;
    end
    chk("busy flag", {7'h00, s[1]}, 8'h00);
  endtask
  task automatic read_byte(input logic [8:0] a, input logic [7:0] exp);
    wr(AHI, {7'h00, a[8]});
    wr(ALO, a[7:0]);
    wr(CTL, 8'h09);
    chk("read stall", {7'h00, cpu_stall}, 8'h01);
    rdchk("stored byte", DAT, exp);
  endtask
  task automatic prog(input logic [1:0] m, input logic [8:0] a, input logic [7:0] d, input logic [7:0] exp);
    wr(AHI, {7'h00, a[8]});
    wr(ALO, a[7:0]);
    wr(DAT, d);
    wr(CTL, {2'h0, m, 4'hc});
    wr(CTL, {2'h0, m, 4'ha});
    if (m != nvbac_pkg::MODE_RSVD) begin
      chk("start stall", {7'h00, cpu_stall}, 8'h01);
      chk("ready request while busy", {7'h00, ready_irq}, 8'h00);
      wr(CTL, {2'h0, ~m, 4'h8});
      wr(ALO, ~a[7:0]);
      rdchk("control while busy", CTL, {2'h0, m, 4'ha});
      wait_ready();
      chk("ready request when idle", {7'h00, ready_irq}, 8'h01);
      rdchk("low address after busy", ALO, a[7:0]);
    end else begin
      chk("stall after refused start", {7'h00, cpu_stall}, 8'h00);
      rdchk("control after refused start", CTL, 8'h38);
    end
    read_byte(a, exp);
  endtask
  // ----------------------------------------
  // Test sequence
  // ----------------------------------------
  initial begin
    err_count = 0;
    cmp_count = 0;
    rst       = 1'h1;
    por       = 1'h1;
    io_wr     = 1'h0;
    io_rd     = 1'h0;
    io_addr   = 6'h00;
    io_wdata  = 8'h00;
    repeat (2) @(posedge ref_clk);
    @(negedge ref_clk);
    rst = 1'h0;
    por = 1'h0;
    rdchk("control after reset", CTL, 8'h00);
    wr(CTL, 8'hc8);
    rdchk("control reserved bits", CTL, 8'h08);
    wr(AHI, 8'hff);
    rdchk("high address", AHI, 8'h01);
    wr(ALO, 8'h5a);
    rdchk("low address", ALO, 8'h5a);
    wr(DAT, 8'h96);
    rdchk("data register", DAT, 8'h96);
    rdchk("unmapped offset", 6'h00, 8'h00);
    prog(2'h0, 9'h000, 8'ha5, 8'ha5);
    prog(2'h0, 9'h1ff, 8'h5a, 8'h5a);
    prog(2'h0, 9'h1a5, 8'h3c, 8'h3c);
    prog(2'h1, 9'h1a5, 8'h00, 8'hff);
    prog(2'h2, 9'h1a5, 8'h0f, 8'h0f);
    prog(2'h2, 9'h1a5, 8'hf3, 8'h03);
    prog(2'h3, 9'h1a5, 8'h00, 8'h03);
    wr(CTL, 8'h0c);
    rdchk("master enable open", CTL, 8'h0c);
    repeat (2) @(negedge ref_clk);
    rdchk("master enable expired", CTL, 8'h08);
    wr(CTL, 8'h0a);
    rdchk("late start refused", CTL, 8'h08);
    wr(AHI, 8'h00);
    wr(ALO, 8'h55);
    wr(CTL, 8'h1c);
    wr(CTL, 8'h1a);
    @(negedge ref_clk);
    rst = 1'h1;
    @(negedge ref_clk);
    rst = 1'h0;
    rdchk("mode kept over busy reset", CTL, 8'h12);
    wait_ready();
    read_byte(9'h055, 8'hff);
    wr(CTL, 8'h28);
    @(negedge ref_clk);
    rst = 1'h1;
    @(negedge ref_clk);
    rst = 1'h0;
    rdchk("mode cleared by reset", CTL, 8'h00);
    tally_and_finish();
  end

  initial begin
    #100000;
    err_count++;
    tally_and_finish();
  end
endmodule
